/* tb_top.sv */
// Self-checking bench of the timer/event counter.
// Assumes tecirq_pkg and the design files are compiled first.
`timescale 1ns/1ps

module tb_top;
	import tecirq_pkg::*;
	localparam int P = 4;
	localparam int LD = 0, TS = 1, ES = 2, SP = 3, JO = 4, EE = 5;
	localparam int ED = 6, TE = 7, TD = 8, RR = 9, IB = 10;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic int_n = 1'b1;
	logic fire = 1'b0;
	logic [10:0] ins = 11'h000;
	logic [7:0] acc_data = 8'h00;
	logic pin, ale, flag, low_seen, cond, pend, call;
	logic [7:0] cnt, vec;
	tecirq_mode_t mode;
	int fail_count = 0;
	int num_checks = 0;
	int t;

	always #4 clk = ~clk;
	tecirq_evsrc src (.clk(clk), .fire(fire), .pin(pin));
	tecirq_top #(.PRESCALE(P), .LATE_SAMPLE(1'b0)) dut (
		.clk(clk), .srst(srst), .int_n(int_n), .count_input_pin(pin),
		.ale(ale), .counter_load_instr(ins[LD]), .acc_data(acc_data),
		.counter_value(cnt), .timer_start_instr(ins[TS]),
		.event_start_instr(ins[ES]), .counter_stop_instr(ins[SP]),
		.jump_on_overflow_instr(ins[JO]), .overflow_flag(flag),
		.counter_mode(mode), .ext_irq_enable_instr(ins[EE]),
		.ext_irq_disable_instr(ins[ED]), .timer_irq_enable_instr(ins[TE]),
		.timer_irq_disable_instr(ins[TD]),
		.return_restore_instr(ins[RR]), .instr_boundary(ins[IB]),
		.jump_if_irq_low_instr(low_seen), .irq_condition(cond),
		.timer_irq_pending(pend), .irq_call(call), .irq_vector(vec)
	);

	////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic pulse(input int i);
		@(negedge clk);
		ins[i] = 1'b1;
		@(negedge clk);
		ins[i] = 1'b0;
	endtask : pulse

	// Clocks until the counter moves
	task automatic wait_cnt;
		logic [7:0] v;
		v = cnt;
		t = 0;
		while (cnt === v && t < 400) begin
			@(negedge clk);
			t++;
		end
		chk("moved", 8'h01, {7'h00, cnt !== v});
	endtask : wait_cnt

	task automatic close_out;
		if (fail_count == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////////
	initial begin
		#50000;
		fail_count++;
		close_out();
	end

	initial begin
		repeat (5) @(negedge clk);
		srst = 1'b0;
		chk("count", 8'h00, cnt);
		chk("mode", 8'h00, {6'h00, mode});
		chk("flag", 8'h00, {7'h00, flag});
		chk("pend", 8'h00, {7'h00, pend});
		int_n = 1'b0;
		pulse(IB);
		chk("call", 8'h00, {7'h00, call});
		chk("low", 8'h01, {7'h00, low_seen});
		chk("cond", 8'h01, {7'h00, cond});
		int_n = 1'b1;
		t = 0;
		repeat (50) begin
			@(negedge clk);
			t += ale;
		end
		chk("ale", 8'h0A, t[7:0]);
		acc_data = 8'hFE;
		pulse(LD);
		chk("load", 8'hFE, cnt);
		pulse(TE);
		pulse(TS);
		repeat (P*5-8) @(negedge clk);
		pulse(TS);
		wait_cnt();
		chk("first", 8'h01, {7'h00, t >= (P-1)*5 && t <= P*5+1});
		wait_cnt();
		chk("period", 8'(P*5), t[7:0]);
		chk("wrap", 8'h00, cnt);
		chk("flag", 8'h01, {7'h00, flag});
		chk("pend", 8'h01, {7'h00, pend});
		chk("cond", 8'h01, {7'h00, cond});
		pulse(SP);
		repeat (P*5+5) @(negedge clk);
		chk("stop", 8'h00, cnt);
		int_n = 1'b0;
		pulse(EE);
		pulse(IB);
		chk("vec", 8'h03, vec);
		chk("pend", 8'h01, {7'h00, pend});
		pulse(IB);
		chk("call", 8'h00, {7'h00, call});
		int_n = 1'b1;
		pulse(RR);
		pulse(IB);
		chk("call", 8'h01, {7'h00, call});
		chk("vec", 8'h07, vec);
		chk("pend", 8'h00, {7'h00, pend});
		pulse(RR);
		pulse(JO);
		chk("flag", 8'h00, {7'h00, flag});
		acc_data = 8'hFF;
		pulse(LD);
		pulse(TS);
		wait_cnt();
		chk("pend", 8'h01, {7'h00, pend});
		pulse(TD);
		chk("pend", 8'h00, {7'h00, pend});
		pulse(IB);
		chk("call", 8'h00, {7'h00, call});
		int_n = 1'b0;
		pulse(ED);
		pulse(IB);
		chk("call", 8'h00, {7'h00, call});
		chk("low", 8'h01, {7'h00, low_seen});
		int_n = 1'b1;
		pulse(SP);
		acc_data = 8'h00;
		pulse(LD);
		pulse(ES);
		chk("mode", 8'h02, {6'h00, mode});
		repeat (3) begin
			fire <= 1'b1;
			@(negedge clk);
			fire <= 1'b0;
			repeat (25) @(negedge clk);
		end
		chk("events", 8'h03, cnt);
		close_out();
	end
endmodule : tb_top

/* tecirq_cycle.sv */
// Five-state machine-cycle generator with address latch strobe.
// Assumes clk is the state-time clock and srst the processor reset.
`timescale 1ns/1ps
`include "tecirq_params.svh"

module tecirq_cycle #(
	parameter bit LATE_SAMPLE = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Timing strobes
	tecirq_tick_if.src tk
);
	import tecirq_pkg::*;

	tecirq_tstate_t s_reg;
	tecirq_tstate_t s_next;

	always_comb begin
		s_next = s_reg;
		if (s_reg.state == `TECIRQ_LAST_STATE) begin
			s_next.state = 3'h0;
		end else begin
			s_next.state = s_reg.state + 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Strobes decoded from the state count
	assign tk.ale = (s_reg.state == `TECIRQ_LAST_STATE);
	assign tk.cycle_end = (s_reg.state == `TECIRQ_LAST_STATE);
	assign tk.sample_stb = (s_reg.state == (LATE_SAMPLE ?
		`TECIRQ_SAMPLE_LATE : `TECIRQ_SAMPLE_EARLY));

	AST_ALE_PERIOD: assert property (@(posedge clk) disable iff (srst)
		tk.ale |=> !tk.ale [*4] ##1 tk.ale)
		else $error("address latch strobe period is not five states");

endmodule : tecirq_cycle

/* tecirq_evsrc.sv */
// Event source model driving the count input pin.
// Assumes clk is the state-time clock, five per machine cycle.
`timescale 1ns/1ps

module tecirq_evsrc (
	// Clock
	input wire logic clk,
	// Request and pin
	input wire logic fire,
	output logic pin
);
	int n = 0;
	always @(negedge clk) begin
		if (n > 0) begin
			n <= n - 1;
		end else if (fire) begin
			n <= 15;
		end
		pin <= (n <= 5);
	end
endmodule : tecirq_evsrc

/* tecirq_params.svh */
// Constants of the timer/event counter with interrupt logic.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef TECIRQ_PARAMS_SVH
`define TECIRQ_PARAMS_SVH

`define TECIRQ_STATES 5
`define TECIRQ_LAST_STATE 3'h4
`define TECIRQ_SAMPLE_EARLY 3'h2
`define TECIRQ_SAMPLE_LATE 3'h3
`define TECIRQ_PRESCALE 32
`define TECIRQ_CNT_MAX 8'hFF
`define TECIRQ_CNT_RESET 8'h00
`define TECIRQ_VEC_EXT 8'h03
`define TECIRQ_VEC_TMR 8'h07

`endif

/* tecirq_pkg.sv */
// Types of the timer/event counter with interrupt logic.
// Assumes tecirq_params.svh is on the include path.
`include "tecirq_params.svh"

package tecirq_pkg;

	typedef enum logic [1:0] {
		TECIRQ_STOPPED,
		TECIRQ_TIMER,
		TECIRQ_EVENT
	} tecirq_mode_t;

	typedef struct packed {
		logic [2:0] state;
	} tecirq_tstate_t;

	typedef struct packed {
		logic [7:0] count;
		tecirq_mode_t mode;
		logic [7:0] presc;
		logic pin_last;
		logic ovf_flag;
		logic tmr_pend;
		logic ext_en;
		logic tmr_en;
		logic in_service;
		logic call;
		logic [7:0] vector;
		logic irq_low;
	} tecirq_state_t;

endpackage : tecirq_pkg

/* tecirq_tick_if.sv */
// Machine-cycle timing strobes passed from the cycle generator.
// Assumes one clock per state time.
`timescale 1ns/1ps

interface tecirq_tick_if;
	logic ale;
	logic sample_stb;
	logic cycle_end;
	modport src (output ale, output sample_stb, output cycle_end);
	modport dst (input ale, input sample_stb, input cycle_end);
endinterface : tecirq_tick_if

/* tecirq_top.sv */
// Timer/event counter with overflow flag and interrupt logic.
// Assumes instruction inputs are one-clock pulses from the sequencer.
`timescale 1ns/1ps
`include "tecirq_params.svh"

module tecirq_top #(
	parameter int PRESCALE = `TECIRQ_PRESCALE,
	parameter bit LATE_SAMPLE = 1'b0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Pins
	input wire logic int_n,
	input wire logic count_input_pin,
	output logic ale,
	// Counter transfer
	input wire logic counter_load_instr,
	input wire logic [7:0] acc_data,
	output logic [7:0] counter_value,
	// Counter control
	input wire logic timer_start_instr,
	input wire logic event_start_instr,
	input wire logic counter_stop_instr,
	input wire logic jump_on_overflow_instr,
	output logic overflow_flag,
	output tecirq_pkg::tecirq_mode_t counter_mode,
	// Interrupt control
	input wire logic ext_irq_enable_instr,
	input wire logic ext_irq_disable_instr,
	input wire logic timer_irq_enable_instr,
	input wire logic timer_irq_disable_instr,
	input wire logic return_restore_instr,
	input wire logic instr_boundary,
	output logic jump_if_irq_low_instr,
	output logic irq_condition,
	output logic timer_irq_pending,
	output logic irq_call,
	output logic [7:0] irq_vector
);
	import tecirq_pkg::*;

	if (PRESCALE < 2 || PRESCALE > 256) begin : g_bad_prescale
		$error("PRESCALE must lie between 2 and 256");
	end

	localparam logic [7:0] PRESC_LAST = 8'(PRESCALE - 1);

	tecirq_tick_if tk ();
	tecirq_state_t st_reg;
	tecirq_state_t st_next;
	logic ext_req;
	logic inc;
	logic wrap;
	logic take;
	logic pin_fall;

	////////////////////////////////////////////////////////////////////////
	// Machine-cycle timing
	tecirq_cycle #(
		.LATE_SAMPLE(LATE_SAMPLE)
	) u_cycle (
		.clk(clk),
		.srst(srst),
		.tk(tk)
	);

	////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		st_next = st_reg;
		st_next.call = 1'b0;
		ext_req = st_reg.ext_en & ~int_n;
		pin_fall = tk.sample_stb & st_reg.pin_last & ~count_input_pin;
		inc = 1'b0;
		unique case (st_reg.mode)
			TECIRQ_STOPPED: begin
				inc = 1'b0;
			end
			TECIRQ_TIMER: begin
				inc = tk.cycle_end && st_reg.presc == PRESC_LAST;
			end
			TECIRQ_EVENT: begin
				inc = pin_fall;
			end
		endcase
		wrap = inc && st_reg.count == `TECIRQ_CNT_MAX;
		take = instr_boundary & ~st_reg.in_service &
			(ext_req | (st_reg.tmr_en & st_reg.tmr_pend));
		// Pin sampling point
		if (tk.sample_stb) begin
			st_next.pin_last = count_input_pin;
		end
		st_next.irq_low = ~int_n;
		// Prescaler
		if (st_reg.mode == TECIRQ_TIMER && tk.cycle_end) begin
			st_next.presc = (st_reg.presc == PRESC_LAST) ? 8'h00 :
				st_reg.presc + 8'h01;
		end
		// Counter
		if (counter_load_instr) begin
			st_next.count = acc_data;
		end else if (inc) begin
			st_next.count = st_reg.count + 8'h01;
		end
		// Mode
		if (counter_stop_instr) begin
			st_next.mode = TECIRQ_STOPPED;
		end else if (timer_start_instr) begin
			st_next.mode = TECIRQ_TIMER;
			st_next.presc = 8'h00;
		end else if (event_start_instr) begin
			st_next.mode = TECIRQ_EVENT;
		end
		// Enables
		if (ext_irq_enable_instr) begin
			st_next.ext_en = 1'b1;
		end else if (ext_irq_disable_instr) begin
			st_next.ext_en = 1'b0;
		end
		if (timer_irq_enable_instr) begin
			st_next.tmr_en = 1'b1;
		end else if (timer_irq_disable_instr) begin
			st_next.tmr_en = 1'b0;
			st_next.tmr_pend = 1'b0;
		end
		// Overflow flag, set wins over clear
		if (jump_on_overflow_instr) begin
			st_next.ovf_flag = 1'b0;
		end
		// Interrupt acceptance
		if (return_restore_instr) begin
			st_next.in_service = 1'b0;
		end
		if (take) begin
			st_next.in_service = 1'b1;
			st_next.call = 1'b1;
			if (ext_req) begin
				st_next.vector = `TECIRQ_VEC_EXT;
			end else begin
				st_next.vector = `TECIRQ_VEC_TMR;
				st_next.tmr_pend = 1'b0;
			end
		end
		if (wrap) begin
			st_next.ovf_flag = 1'b1;
			if (st_reg.tmr_en && !timer_irq_disable_instr) begin
				st_next.tmr_pend = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk) begin
		if (srst) begin
			st_reg <= '0;
			st_reg.count <= `TECIRQ_CNT_RESET;
			st_reg.mode <= TECIRQ_STOPPED;
			st_reg.vector <= `TECIRQ_VEC_EXT;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign ale = tk.ale;
	assign counter_value = st_reg.count;
	assign counter_mode = st_reg.mode;
	assign overflow_flag = st_reg.ovf_flag;
	assign jump_if_irq_low_instr = st_reg.irq_low;
	assign timer_irq_pending = st_reg.tmr_pend;
	assign irq_condition = ~int_n | st_reg.tmr_pend;
	assign irq_call = st_reg.call;
	assign irq_vector = st_reg.vector;

	////////////////////////////////////////////////////////////////////////
	// Checks
	AST_EXT_OFF_AFTER_RESET: assert property (@(posedge clk)
		$fell(srst) && !ext_irq_enable_instr |=> !st_reg.ext_en)
		else $error("external interrupt enabled without instruction");

	AST_WRAP_FLAG: assert property (@(posedge clk) disable iff (srst)
		wrap && !counter_load_instr |=> st_reg.count == 8'h00 &&
		st_reg.ovf_flag)
		else $error("wrap did not clear count and set flag");

	AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (srst)
		jump_on_overflow_instr && !wrap |=> !overflow_flag)
		else $error("overflow flag not cleared by jump");

	AST_STOP_HOLDS: assert property (@(posedge clk) disable iff (srst)
		st_reg.mode == TECIRQ_STOPPED && !counter_load_instr |=>
		$stable(st_reg.count))
		else $error("stopped counter changed");

	AST_START_CLEARS_PRESC: assert property (@(posedge clk)
		disable iff (srst)
		timer_start_instr && !counter_stop_instr |=>
		st_reg.presc == 8'h00 && st_reg.mode == TECIRQ_TIMER)
		else $error("timer start did not clear prescaler");

	AST_TIMER_STEP: assert property (@(posedge clk) disable iff (srst)
		st_reg.mode == TECIRQ_TIMER && tk.cycle_end &&
		st_reg.presc == PRESC_LAST && !counter_load_instr |=>
		st_reg.count == $past(st_reg.count) + 8'h01)
		else $error("timer did not step at prescaler end");

	AST_EVENT_STEP: assert property (@(posedge clk) disable iff (srst)
		st_reg.mode == TECIRQ_EVENT && pin_fall && !counter_load_instr
		|=> st_reg.count == $past(st_reg.count) + 8'h01)
		else $error("falling count pin did not step counter");

	AST_EXT_FIRST: assert property (@(posedge clk) disable iff (srst)
		take && ext_req |=> irq_call && irq_vector == 8'h03)
		else $error("external interrupt not given priority");

	AST_TMR_CALL: assert property (@(posedge clk) disable iff (srst)
		take && !ext_req && !wrap |=> irq_vector == 8'h07 &&
		!timer_irq_pending)
		else $error("timer call did not clear pending latch");

	AST_SINGLE_LEVEL: assert property (@(posedge clk) disable iff (srst)
		irq_call ##1 !return_restore_instr [*2] |=> !irq_call)
		else $error("interrupt taken while one is in service");

endmodule : tecirq_top
